/* File: rtl/drc_pkg.sv */
/*
  Shared constants and types for the transfer request and bus cycle controller.
  Assumes a single 250 MHz clock domain and a plain register port.
*/
package drc_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int DRC_NCH     = 4;
    localparam int DRC_DW      = 32;
    localparam int DRC_AW      = 8;
    localparam int DRC_FIFO_D  = 8;
    localparam int DRC_BSZ_W   = 16;

    // ------------------------------------------------------------
    // Register map: channel in addr[6:5], index in addr[4:2]
    // ------------------------------------------------------------
    localparam int         DRC_CH_LSB  = 5;
    localparam int         DRC_IDX_LSB = 2;
    localparam logic [2:0] DRC_IDX_CTRL = 3'h0;
    localparam logic [2:0] DRC_IDX_SRC  = 3'h1;
    localparam logic [2:0] DRC_IDX_DST  = 3'h2;
    localparam logic [2:0] DRC_IDX_CNT  = 3'h3;
    localparam logic [2:0] DRC_IDX_BSZ  = 3'h4;

    // Read-only status bits above the control field
    localparam int DRC_ACT_BIT  = 11;
    localparam int DRC_PEND_BIT = 12;

    // ------------------------------------------------------------
    // Unit sizes
    // ------------------------------------------------------------
    localparam logic [1:0]  DRC_SZ_BYTE = 2'h0;
    localparam logic [1:0]  DRC_SZ_WORD = 2'h1;
    localparam logic [31:0] DRC_STEP_B  = 32'h1;
    localparam logic [31:0] DRC_STEP_W  = 32'h2;
    localparam logic [31:0] DRC_STEP_L  = 32'h4;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] size;
        logic       transfer_end_pin_en;
        logic       dir_wr;
        logic       single;
        logic       block;
        logic       burst;
        logic       edge_mode;
        logic       pin_en;
        logic       next_request_delay_bit;
        logic       channel_enable_bit;
    } drc_ctrl_type;

    localparam drc_ctrl_type DRC_CTRL_RST = 11'h000;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [1:0]  size;
        logic [31:0] addr;
    } drc_mem_type;

    typedef enum logic [3:0] {
        DRC_IDLE  = 4'b0001,
        DRC_READ  = 4'b0010,
        DRC_WRITE = 4'b0100,
        DRC_REL   = 4'b1000
    } drc_state_type;

endpackage

/* File: rtl/drc_top.sv */
/*
  Transfer request sampling, channel arbitration and bus cycle sequencing,
  plus the data FIFO module it uses.
  Assumes memory acknowledges on the same clock and request pins are asynchronous.
*/
// Implementation choices: the register addresses and the plain strobed port.
// How it works
// - Cycle-steal mode releases the bus after every single unit.
// - Burst mode keeps transferring units back to back until the end.
// - A running burst or block is never preempted by higher channels.
// - Block mode moves a whole block per request, then releases.
// - Request pin is sampled every cycle from the edge after enabling.
// - Low sampled pin with pin triggering enabled latches a pending request.
// - Activating the channel clears its pending request.
// - Edge mode needs a high level seen before a new low counts.
// - Dual edge mode: high must be seen after activation, before or after write end, for next request.
// - Dual level mode: acceptance resumes after the write cycle finishes.
// - Delay bit set postpones request acceptance by one extra cycle.
// - Single-address mode moves one unit per request, then releases bus.
// - Single edge mode: high must be seen after activation, before or after the single cycle ends.
// - Single level mode: acceptance resumes after the single cycle completes.
// - Single mode with delay bit adds one ignore cycle after completion.
// - Dual mode reads then writes with no bus release between them.
// - Fixed priority: channel 0 highest, then 1, 2, 3.
`timescale 1ns/1ns

module drc_fifo
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
)
(
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_reg != (PW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o  = mem_reg[rd_ptr_reg];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_ff @(posedge clock_i)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

module drc_top
    import drc_pkg::*;
#(
    parameter int NCH    = DRC_NCH,
    parameter int FIFO_D = DRC_FIFO_D
)
(
    input  wire logic              clock_i,
    input  wire logic              reset_i,
    input  wire logic [DRC_AW-1:0] reg_addr_i,
    input  wire logic [DRC_DW-1:0] reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic [DRC_DW-1:0]      reg_rdata_o,
    input  wire logic [NCH-1:0]    dma_request_pin_n_i,
    output logic [NCH-1:0]         transfer_end_pin_n_o,
    output logic [NCH-1:0]         dack_o,
    output drc_mem_type            mem_o,
    output logic [DRC_DW-1:0]      mem_wdata_o,
    input  wire logic [DRC_DW-1:0] mem_rdata_i,
    input  wire logic              mem_ack_i,
    output logic                   bus_busy_o,
    input  wire logic              pin_in_valid_i,
    output logic                   pin_in_ready_o,
    input  wire logic [DRC_DW-1:0] pin_in_data_i,
    output logic                   pin_out_valid_o,
    input  wire logic              pin_out_ready_i,
    output logic [DRC_DW-1:0]      pin_out_data_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] first_set(input logic [NCH-1:0] v);
        logic [1:0] r;
        r = '0;
        for (int i = NCH-1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] size_step(input logic [1:0] s);
        logic [31:0] r;
        case (s)
            DRC_SZ_BYTE: r = DRC_STEP_B;
            DRC_SZ_WORD: r = DRC_STEP_W;
            default:     r = DRC_STEP_L;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    drc_ctrl_type         ctrl_reg [NCH];
    logic [31:0]          src_reg [NCH];
    logic [31:0]          dst_reg [NCH];
    logic [31:0]          cnt_reg [NCH];
    logic [DRC_BSZ_W-1:0] bsz_reg [NCH];
    logic [NCH-1:0]       sync1_reg;
    logic [NCH-1:0]       sync2_reg;
    logic [NCH-1:0]       pend_reg;
    logic [NCH-1:0]       arm_reg;
    logic [NCH-1:0]       hi_reg;
    logic [NCH-1:0]       dly_reg;
    drc_state_type        state_reg;
    drc_state_type        state_next;
    logic [1:0]           chan_reg;
    logic [DRC_BSZ_W-1:0] blk_left_reg;
    logic [DRC_DW-1:0]    rdata_reg;

    // ------------------------------------------------------------
    // Decode and current-channel view
    // ------------------------------------------------------------
    logic [1:0]     wr_ch;
    logic [2:0]     wr_idx;
    logic [NCH-1:0] req;
    logic [NCH-1:0] act;
    logic [NCH-1:0] fin;
    logic [NCH-1:0] en_wr;
    drc_ctrl_type   cur;
    logic [31:0]    step;
    logic [31:0]    cur_cnt;
    logic           busy;
    logic           last;
    logic           unit_done;
    logic           cont;
    logic           start_wr;
    logic           fifo_in_valid;
    logic           fifo_in_ready;
    logic [31:0]    fifo_in_data;
    logic           fifo_out_valid;
    logic           fifo_out_ready;
    logic [31:0]    fifo_out_data;
    logic           dual_busy;
    logic           out_en;

    assign wr_ch   = reg_addr_i[DRC_CH_LSB +: 2];
    assign wr_idx  = reg_addr_i[DRC_IDX_LSB +: 3];
    assign cur     = ctrl_reg[chan_reg];
    assign step    = size_step(cur.size);
    assign cur_cnt = cnt_reg[chan_reg];
    assign busy    = (state_reg == DRC_READ) | (state_reg == DRC_WRITE);
    // Count of zero means uncounted, so it never ends the transfer
    assign last     = (cur_cnt != '0) & (cur_cnt <= step);
    assign start_wr = cur.single & cur.dir_wr;
    // A unit ends on the write ack, or on the read ack in single read
    assign unit_done = mem_ack_i & ((state_reg == DRC_WRITE) |
                       ((state_reg == DRC_READ) & cur.single));
    // Block keeps going to its end even after enable is cleared
    // Single address never chains units, whatever burst or block say
    assign cont = ~last & ~cur.single & ((cur.block & (blk_left_reg > DRC_BSZ_W'(1))) |
                  (cur.burst & ~cur.block & cur.channel_enable_bit));

    always_comb
    begin
        for (int c = 0; c < NCH; c++)
        begin
            req[c]   = ctrl_reg[c].channel_enable_bit & (ctrl_reg[c].pin_en ? pend_reg[c] : 1'b1);
            act[c]   = (state_reg == DRC_IDLE) & (|req) & (first_set(req) == 2'(c));
            fin[c]   = unit_done & (chan_reg == 2'(c));
            en_wr[c] = reg_wr_i & (wr_idx == DRC_IDX_CTRL) & (wr_ch == 2'(c));
        end
    end

    // ------------------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            DRC_IDLE:
            begin
                if (|req)
                begin
                    state_next = (ctrl_reg[first_set(req)].single & ctrl_reg[first_set(req)].dir_wr)
                                 ? DRC_WRITE : DRC_READ;
                end
            end
            DRC_READ:
            begin
                if (mem_ack_i & ~cur.single)
                begin
                    state_next = DRC_WRITE;
                end
                else if (unit_done)
                begin
                    state_next = cont ? DRC_READ : DRC_REL;
                end
            end
            DRC_WRITE:
            begin
                if (unit_done)
                begin
                    // Channel stays locked while continuing
                    state_next = cont ? (start_wr ? DRC_WRITE : DRC_READ) : DRC_REL;
                end
            end
            DRC_REL:    state_next = DRC_IDLE;
            default:    state_next = DRC_IDLE;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            state_reg <= DRC_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            chan_reg     <= '0;
            blk_left_reg <= '0;
        end
        else if (state_reg == DRC_IDLE)
        begin
            if (|req)
            begin
                chan_reg     <= first_set(req);
                blk_left_reg <= bsz_reg[first_set(req)];
            end
        end
        else if (unit_done)
        begin
            blk_left_reg <= blk_left_reg - DRC_BSZ_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Request pin sampling
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            sync1_reg <= '1;
            sync2_reg <= '1;
        end
        else
        begin
            sync1_reg <= dma_request_pin_n_i;
            sync2_reg <= sync1_reg;
        end
    end

    // Latching disarms, so the still-low pin cannot re-latch at activation
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            pend_reg <= '0;
            arm_reg  <= '0;
            hi_reg   <= '0;
            dly_reg  <= '0;
        end
        else
        begin
            for (int c = 0; c < NCH; c++)
            begin
                if (en_wr[c] & reg_wdata_i[0] & ~ctrl_reg[c].channel_enable_bit)
                begin
                    pend_reg[c] <= 1'b0;
                    arm_reg[c]  <= 1'b1;
                    hi_reg[c]   <= 1'b1;
                    dly_reg[c]  <= 1'b0;
                end
                else if (~ctrl_reg[c].channel_enable_bit)
                begin
                    pend_reg[c] <= 1'b0;
                end
                else
                begin
                    if (ctrl_reg[c].pin_en & arm_reg[c] & ~sync2_reg[c] &
                        (~ctrl_reg[c].edge_mode | hi_reg[c]))
                    begin
                        pend_reg[c] <= 1'b1;
                        arm_reg[c]  <= 1'b0;
                        hi_reg[c]   <= 1'b0;
                    end
                    else if (act[c])
                    begin
                        pend_reg[c] <= 1'b0;
                        hi_reg[c]   <= 1'b0;
                    end
                    else if (sync2_reg[c])
                    begin
                        hi_reg[c] <= 1'b1;
                    end
                    if (fin[c])
                    begin
                        // Resume point is the write or single cycle end
                        arm_reg[c] <= ~ctrl_reg[c].next_request_delay_bit;
                        dly_reg[c] <= ctrl_reg[c].next_request_delay_bit;
                    end
                    else if (dly_reg[c])
                    begin
                        arm_reg[c] <= 1'b1;
                        dly_reg[c] <= 1'b0;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Channel registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                ctrl_reg[c] <= DRC_CTRL_RST;
            end
        end
        else
        begin
            for (int c = 0; c < NCH; c++)
            begin
                // Software write wins over the hardware clear
                if (en_wr[c])
                begin
                    ctrl_reg[c] <= drc_ctrl_type'(reg_wdata_i[DRC_ACT_BIT-1:0]);
                end
                else if (fin[c] & last)
                begin
                    ctrl_reg[c].channel_enable_bit <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                src_reg[c] <= '0;
                dst_reg[c] <= '0;
                cnt_reg[c] <= '0;
                bsz_reg[c] <= '0;
            end
        end
        else
        begin
            for (int c = 0; c < NCH; c++)
            begin
                if (reg_wr_i & (wr_ch == 2'(c)))
                begin
                    if (wr_idx == DRC_IDX_SRC) src_reg[c] <= reg_wdata_i;
                    if (wr_idx == DRC_IDX_DST) dst_reg[c] <= reg_wdata_i;
                    if (wr_idx == DRC_IDX_CNT) cnt_reg[c] <= reg_wdata_i;
                    if (wr_idx == DRC_IDX_BSZ) bsz_reg[c] <= reg_wdata_i[DRC_BSZ_W-1:0];
                end
                else if (mem_ack_i & busy & (chan_reg == 2'(c)))
                begin
                    if (state_reg == DRC_READ) src_reg[c] <= src_reg[c] + step;
                    if (state_reg == DRC_WRITE) dst_reg[c] <= dst_reg[c] + step;
                    if (unit_done & (cnt_reg[c] != '0))
                    begin
                        cnt_reg[c] <= last ? '0 : cnt_reg[c] - step;
                    end
                end
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            rdata_reg <= '0;
        end
        else if (reg_rd_i)
        begin
            case (wr_idx)
                DRC_IDX_CTRL:
                begin
                    rdata_reg <= '0;
                    rdata_reg[DRC_ACT_BIT-1:0] <= ctrl_reg[wr_ch];
                    rdata_reg[DRC_ACT_BIT]     <= busy & (chan_reg == wr_ch);
                    rdata_reg[DRC_PEND_BIT]    <= pend_reg[wr_ch];
                end
                DRC_IDX_SRC: rdata_reg <= src_reg[wr_ch];
                DRC_IDX_DST: rdata_reg <= dst_reg[wr_ch];
                DRC_IDX_CNT: rdata_reg <= cnt_reg[wr_ch];
                DRC_IDX_BSZ: rdata_reg <= 32'(bsz_reg[wr_ch]);
                default:     rdata_reg <= '0;
            endcase
        end
        else
        begin
            rdata_reg <= '0;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // ------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------
    // Peripheral stream is kept off the FIFO while a dual transfer owns it
    assign dual_busy = busy & ~cur.single;
    assign out_en    = ~dual_busy & ~(busy & start_wr);

    assign fifo_in_valid   = ((state_reg == DRC_READ) & mem_ack_i) | (~dual_busy & (state_reg != DRC_READ) & pin_in_valid_i);
    assign fifo_in_data    = (state_reg == DRC_READ) ? mem_rdata_i : pin_in_data_i;
    assign pin_in_ready_o  = fifo_in_ready & ~dual_busy & (state_reg != DRC_READ);
    assign fifo_out_ready  = ((state_reg == DRC_WRITE) & mem_ack_i) | (out_en & pin_out_ready_i);
    assign pin_out_valid_o = fifo_out_valid & out_en;
    assign pin_out_data_o  = fifo_out_data;
    assign mem_wdata_o     = fifo_out_data;

    drc_fifo
    #(
        .WIDTH (DRC_DW),
        .DEPTH (FIFO_D)
    )
    u_fifo
    (
        .clock_i     (clock_i),
        .reset_i     (reset_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out_data)
    );

    // ------------------------------------------------------------
    // Bus and pin outputs
    // ------------------------------------------------------------
    // Read waits for FIFO room, write for FIFO data: back-pressure to memory
    assign mem_o.req  = ((state_reg == DRC_READ) & fifo_in_ready) | ((state_reg == DRC_WRITE) & fifo_out_valid);
    assign mem_o.we   = (state_reg == DRC_WRITE);
    assign mem_o.size = cur.size;
    assign mem_o.addr = (state_reg == DRC_WRITE) ? dst_reg[chan_reg] : src_reg[chan_reg];
    assign bus_busy_o = busy;

    always_comb
    begin
        for (int c = 0; c < NCH; c++)
        begin
            dack_o[c] = busy & cur.single & (chan_reg == 2'(c));
            transfer_end_pin_n_o[c] = ~(busy & last & cur.transfer_end_pin_en & (chan_reg == 2'(c)));
        end
    end

endmodule

/* File: testbench/drc_mem_model.sv */
/*
  Memory on the far side of the bus port.
  Assumes a request stands until it is acknowledged.
*/
`timescale 1ns/1ns
module drc_mem_model
    import drc_pkg::*;
(
    input  wire logic         clock_i,
    input  wire logic         reset_i,
    input  wire drc_mem_type  mem_i,
    input  wire logic [1:0]   wait_i,
    output logic              ack_o,
    output logic [DRC_DW-1:0] rdata_o
);
    logic [1:0] wait_reg;
    logic       tog_reg;
    always_ff @(posedge clock_i)
    begin
        wait_reg <= (reset_i || !mem_i.req || ack_o) ? 2'h0 : wait_reg + 2'h1;
        tog_reg  <= reset_i ? 1'b0 : ~tog_reg;
    end
    // Read and its write each answered, promptly or after wait_i cycles
    assign ack_o   = mem_i.req && wait_reg == wait_i;
    // Data churns outside the ack so stale data never passes
    assign rdata_o = ack_o ? ~mem_i.addr : {DRC_DW{tog_reg}};
endmodule

/* File: testbench/drc_sva.sv */
/*
  Port checker for drc_top.
  Assumes one clock domain and a bind from the bench.
*/
`timescale 1ns/1ns
module drc_sva
    import drc_pkg::*;
#(
    parameter int NCH = 4
)
(
    input wire logic           clock_i,
    input wire logic           reset_i,
    input wire logic [NCH-1:0] transfer_end_pin_n_o,
    input wire logic [NCH-1:0] dack_o,
    input wire drc_mem_type    mem_o,
    input wire logic           mem_ack_i,
    input wire logic           bus_busy_o
);
    // ----------------
    // Bus ownership
    // ----------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);
    chk_rd_then_wr: assert property (
        mem_o.req && !mem_o.we && mem_ack_i && dack_o == '0 |=> mem_o.req && mem_o.we)
        else $error("no write after read");
    chk_req_hold: assert property (
        mem_o.req && !mem_ack_i |=> mem_o.req && $stable(mem_o.addr) && $stable(mem_o.we))
        else $error("request moved before ack");
    chk_req_owned: assert property (mem_o.req |-> bus_busy_o)
        else $error("request without bus");
    chk_dack_single: assert property (|dack_o |-> bus_busy_o && $onehot(dack_o))
        else $error("bad acknowledge");
    chk_single_rel: assert property (|dack_o && mem_ack_i |=> !bus_busy_o)
        else $error("bus kept after single unit");
    chk_transfer_end_pin_busy: assert property (!(&transfer_end_pin_n_o) |-> bus_busy_o)
        else $error("end pin outside bus cycle");
    chk_transfer_end_pin_one: assert property ($onehot0(~transfer_end_pin_n_o))
        else $error("end pin on two channels");
    // Release must last long enough for another master to get a cycle
    chk_rel_gap: assert property ($fell(bus_busy_o) |=> !bus_busy_o)
        else $error("release too short");
endmodule

/* File: testbench/testbench.sv */
/*
  Self-checking bench for drc_top.
  Assumes the memory model answers the bus port.
*/
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
module testbench;
    import drc_pkg::*;
    logic        clock_i = 0;
    logic        reset_i = 1;
    logic [7:0]  addr    = 0;
    logic [31:0] wdata   = 0;
    logic        wr = 0, rd = 0, pv = 0, pr = 1, ack, busy, prdy, pov;
    logic        pulse = 0, rise = 0, bq = 0;
    logic [3:0]  pin_n = 4'hf, transfer_end_pin_n, dack;
    logic [1:0]  wt = 0;
    logic [31:0] rdata, mrd, a0, wd;
    drc_mem_type mem;
    int          n_mismatch = 0, num_checks = 0, falls, ends, t[$];
    initial forever #2 clock_i = ~clock_i;
    // Peripheral lifts its request for one cycle once the bus is taken
    always @(posedge clock_i) {bq, rise} <= {busy, busy & ~bq};
    drc_top u_dut (.clock_i, .reset_i, .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .dma_request_pin_n_i(pin_n | {3'h0, pulse & rise}),
        .transfer_end_pin_n_o(transfer_end_pin_n),
        .dack_o(dack), .mem_o(mem), .mem_wdata_o(wd), .mem_rdata_i(mrd), .mem_ack_i(ack), .bus_busy_o(busy),
        .pin_in_valid_i(pv), .pin_in_ready_o(prdy), .pin_in_data_i(32'h0), .pin_out_valid_o(pov),
        .pin_out_ready_i(pr), .pin_out_data_o());
    drc_mem_model u_mem (.clock_i, .reset_i, .mem_i(mem), .wait_i(wt), .ack_o(ack), .rdata_o(mrd));
    // ----------------
    // Shared tasks
    // ----------------
    task automatic stop_test();
        if (n_mismatch == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wr_reg(input int a, input logic [31:0] d);
        @(posedge clock_i);
        addr  <= 8'(a);
        wdata <= d;
        wr    <= 1;
        @(posedge clock_i);
        wr <= 0;
    endtask
    task automatic rd_chk(input int a, input logic [31:0] e);
        @(posedge clock_i);
        addr <= 8'(a);
        rd   <= 1;
        @(posedge clock_i);
        rd <= 0;
        #1 `CHK("register", e, rdata)
    endtask
    task automatic setup(input int ch, input logic [31:0] cnt, bsz, ctrl);
        wr_reg(ch * 32 + 4, 32'h100 + 32'(ch * 16));
        wr_reg(ch * 32 + 8, 32'h200);
        wr_reg(ch * 32 + 12, cnt);
        wr_reg(ch * 32 + 16, bsz);
        wr_reg(ch * 32, ctrl);
    endtask
    // Notes each unit end and each bus release until the bus stays quiet
    task automatic run();
        int c, idle;
        logic b;
        logic [31:0] ra;
        t = {};
        falls = 0;
        ends = 0;
        idle = 0;
        b = 0;
        a0 = 0;
        for (c = 0; c < 400 && idle < 12; c++)
        begin
            @(posedge clock_i);
            #1;
            if (ack && (mem.we || dack != 0)) t.push_back(c);
            if (ack && transfer_end_pin_n != 4'hf) ends++;
            if (ack && !mem.we && dack == 0) ra = mem.addr;
            if (ack && mem.we && dack == 0) `CHK("write data", ~ra, wd)
            if (mem.req && a0 == 0) a0 = mem.addr;
            if (b && !busy) falls++;
            idle = busy ? 0 : idle + 1;
            b = busy;
        end
        if (c == 400)
        begin
            n_mismatch++;
            stop_test();
        end
    endtask
    task automatic go(input logic [31:0] ctrl, cnt, bsz, input int units, rels);
        @(posedge clock_i);
        pin_n <= 4'he;
        setup(0, cnt, bsz, ctrl);
        run();
        pin_n <= 4'hf;
        `CHK("units", units, t.size())
        `CHK("releases", rels, falls)
    endtask
    // ----------------
    // Scenarios
    // ----------------
    task automatic t_regs();
        rd_chk(0, 32'h0);
        wr_reg(112, 32'h1234);
        rd_chk(112, 32'h1234);
        rd_chk(116, 32'h0);
    endtask
    task automatic t_modes();
        go(32'h505, 8, 0, 2, 2);
        `CHK("end pin", 2, ends)
        rd_chk(0, 32'h504);
        go(32'h411, 12, 0, 3, 1);
        wt <= 2;
        go(32'h425, 16, 2, 4, 2);
        wt <= 0;
        go(32'h40d, 8, 0, 1, 1);
        wr_reg(0, 32'h0);
        pulse <= 1;
        go(32'h40d, 8, 0, 2, 2);
        go(32'h44d, 8, 0, 2, 2);
        pulse <= 0;
    endtask
    task automatic t_delay(input logic [31:0] mode);
        int g;
        go(mode, 8, 0, 2, 2);
        g = t[1] - t[0];
        go(mode | 32'h2, 8, 0, 2, 2);
        `CHK("delay gap", g + 1, t[1] - t[0])
    endtask
    task automatic t_single();
        pr <= 0;
        go(32'h445, 8, 0, 2, 2);
        `CHK("stalled data", 1'b1, pov)
        pv <= 1;
        repeat (12) @(posedge clock_i);
        #1 `CHK("fifo full", 1'b0, prdy)
        pr <= 1;
        go(32'h4c5, 8, 0, 2, 2);
        pv <= 0;
    endtask
    task automatic t_prio();
        setup(1, 32'h4, 32'h0, 32'h405);
        setup(0, 32'h4, 32'h0, 32'h405);
        pin_n <= 4'hc;
        run();
        pin_n <= 4'hf;
        `CHK("first source", 32'h100, a0)
        `CHK("units", 2, t.size())
    endtask
    initial
    begin
        repeat (20) @(posedge clock_i);
        reset_i <= 0;
        t_regs();
        t_modes();
        t_delay(32'h405);
        t_delay(32'h445);
        t_single();
        t_prio();
        stop_test();
    end
endmodule
bind drc_top drc_sva #(.NCH(NCH)) u_sva (.clock_i, .reset_i, .transfer_end_pin_n_o, .dack_o, .mem_o,
    .mem_ack_i, .bus_busy_o);
